//--- core/tcp_pkg.sv
package tcp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths and register map (byte addresses, one word each).
	localparam int unsigned TCP_CNT_W = 16;
	localparam int unsigned TCP_ADR_W = 8;
	localparam logic [7:0] TCP_OFS_CTRL = 8'h00;
	localparam logic [7:0] TCP_OFS_PERIOD = 8'h04;
	localparam logic [7:0] TCP_OFS_COMPARE = 8'h08;
	localparam logic [7:0] TCP_OFS_COUNT = 8'h0c;
	localparam logic [7:0] TCP_OFS_CAPTURE = 8'h10;
	localparam logic [7:0] TCP_OFS_STATUS = 8'h14;
	localparam logic [7:0] TCP_OFS_MASK = 8'h18;
	localparam logic [7:0] TCP_OFS_PRESCALE = 8'h1c;

	////////////////////////////////////////////////////////////////////////////
	// Field positions of the control word.
	localparam int unsigned TCP_CTRL_EN = 0;
	localparam int unsigned TCP_CTRL_MODE_LSB = 1;
	localparam int unsigned TCP_CTRL_CLK_LSB = 3;
	localparam int unsigned TCP_CTRL_CMP_LSB = 5;
	localparam int unsigned TCP_CTRL_CPL = 8;
	localparam int unsigned TCP_CTRL_DB_LSB = 16;

	// Event bits of the status and mask words, and the running flag.
	localparam int unsigned TCP_EV_TC = 0;
	localparam int unsigned TCP_EV_CMP = 1;
	localparam int unsigned TCP_EV_CAP = 2;
	localparam int unsigned TCP_EV_N = 3;
	localparam int unsigned TCP_ST_RUN = 8;

	////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [15:0] TCP_RST_PERIOD = 16'hffff;
	localparam logic [15:0] TCP_RST_COMPARE = 16'h8000;
	localparam logic [15:0] TCP_RST_PRESCALE = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// Modes and states.
	typedef enum logic [1:0] {
		TCP_RUN_FREE = 2'h0,
		TCP_RUN_ONESHOT = 2'h1,
		TCP_RUN_GATED = 2'h2
	} tcp_run_t;

	typedef enum logic [1:0] {
		TCP_CLK_SYS = 2'h0,
		TCP_CLK_DIV = 2'h1,
		TCP_CLK_EXT_RISE = 2'h2,
		TCP_CLK_EXT_FALL = 2'h3
	} tcp_clk_t;

	typedef enum logic [2:0] {
		TCP_CMP_LESS_THAN = 3'h0,
		TCP_CMP_LESS_OR_EQUAL = 3'h1,
		TCP_CMP_SAME_VALUE = 3'h2,
		TCP_CMP_GREATER_OR_EQUAL = 3'h3,
		TCP_CMP_GREATER_THAN = 3'h4
	} tcp_cmp_t;

	typedef enum logic [2:0] {
		TCP_ST_IDLE = 3'b001,
		TCP_ST_COUNT = 3'b010,
		TCP_ST_HALT = 3'b100
	} tcp_fsm_t;

	// Routed inputs after synchronisation.
	typedef struct packed {
		logic ext_clk;
		logic restart;
		logic capture;
		logic kill;
		logic enable;
	} tcp_pins_t;

endpackage

//--- core/tcp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for routed inputs; only the second stage is visible.
module tcp_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous levels in, synchronous levels out.
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} tcp_sync_state_t;

	tcp_sync_state_t s_q;
	tcp_sync_state_t s_d;

	if (WIDTH < 1) begin : g_chk
		$error("tcp_sync: WIDTH must be at least one");
	end

	// The first stage feeds the second stage and nothing else.
	always_comb begin
		s_d.meta = d_i;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.sync;

endmodule

//--- core/tcp_deadband.sv
`timescale 1ns/1ps
// Complementary output pair with a programmable dead gap after every edge.
module tcp_deadband #(
	parameter int unsigned DB_W = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw compare level, kill and gap length in clocks.
	input wire logic pwm_i,
	input wire logic kill_i,
	input wire logic [DB_W-1:0] dead_i,
	// Registered true and complement outputs.
	output logic hi_o,
	output logic lo_o
);

	typedef struct packed {
		logic prev;
		logic [DB_W-1:0] cnt;
		logic hi;
		logic lo;
	} tcp_db_state_t;

	tcp_db_state_t s_q;
	tcp_db_state_t s_d;

	if (DB_W < 1 || DB_W > 16) begin : g_chk
		$error("tcp_deadband: DB_W must lie in 1..16");
	end

	// Both outputs are off during the gap, so they never overlap.
	always_comb begin
		s_d = s_q;
		if (pwm_i != s_q.prev) begin
			s_d.prev = pwm_i;
			s_d.cnt = dead_i;
			s_d.hi = (dead_i == '0) & pwm_i; // R8
			s_d.lo = (dead_i == '0) & ~pwm_i; // R8
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
			s_d.hi = 1'b0;
			s_d.lo = 1'b0;
		end else begin
			s_d.hi = pwm_i;
			s_d.lo = ~pwm_i;
		end
		// Kill wins over everything and holds both outputs inactive.
		if (kill_i) begin
			s_d.hi = 1'b0; // R7
			s_d.lo = 1'b0; // R7
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hi_o = s_q.hi;
	assign lo_o = s_q.lo;

endmodule

//--- core/tcp_timer.sv
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
// Behaviour
// R1 - Sixteen-bit counter, counts down only.
// R2 - Reload period on start, restart, terminal count; in one-shot the code halts at zero without reloading.
// R3 - Compare modes: less, less-equal, same, greater-equal, greater.
// R4 - Interrupt on terminal count, compare, capture.
// R5 - One-shot halts after the period completes.
// R6 - Free, one-shot or enable-gated counting.
// R7 - Kill forces compare outputs inactive.
// R8 - Complementary outputs with deadband gap.
// R9 - Compare, terminal-count or complement, interrupt outputs.
// R10 - Capture latches full count for software.
// R11 - Outside logic drives restart and capture.
// R12 - Software picks the counter clock source.
// R13 - Zero is terminal count, one-clock pulse.
// R14 - Live count readable without disturbing it.
module tcp_timer
	import tcp_pkg::*;
#(
	parameter int unsigned DB_W = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [TCP_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Routed inputs, asynchronous to clk_i.
	input wire logic ext_clk_i,
	input wire logic restart_i,
	input wire logic capture_i,
	input wire logic kill_i,
	input wire logic enable_i,
	// Routed outputs.
	output logic cmp_o,
	output logic tc_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// State of the whole block.

	typedef struct packed {
		tcp_fsm_t fsm;
		logic en;
		tcp_run_t mode;
		tcp_clk_t clk_src;
		tcp_cmp_t cmp_mode;
		logic cpl;
		logic [DB_W-1:0] dead;
		logic [TCP_CNT_W-1:0] period;
		logic [TCP_CNT_W-1:0] compare;
		logic [TCP_CNT_W-1:0] prescale;
		logic [TCP_CNT_W-1:0] div_cnt;
		logic [TCP_CNT_W-1:0] count;
		logic [TCP_CNT_W-1:0] capture;
		logic [TCP_EV_N-1:0] status;
		logic [TCP_EV_N-1:0] mask;
		tcp_pins_t prev;
		logic cmp_prev;
		logic tc_pulse;
		logic ack;
		logic [31:0] rdata;
	} tcp_state_t;

	tcp_state_t s_q;
	tcp_state_t s_d;
	tcp_pins_t pins;
	logic [4:0] pins_raw;
	logic db_hi;
	logic db_lo;
	logic cmp_true;

	if (DB_W < 1 || DB_W > 16) begin : g_chk
		$error("tcp_timer: DB_W must lie in 1..16");
	end

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisation and output stage.

	// Every routed input passes two flops before any logic here reads it.
	tcp_sync #(
		.WIDTH(5)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({ext_clk_i, restart_i, capture_i, kill_i, enable_i}),
		.q_o(pins_raw)
	);

	// The cast relies on the concatenation above listing the pins in struct order.
	assign pins = tcp_pins_t'(pins_raw);

	// The compare level drives the deadband pair; kill is applied there.
	tcp_deadband #(
		.DB_W(DB_W)
	) u_deadband (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pwm_i(cmp_true & (s_q.fsm != TCP_ST_IDLE)),
		.kill_i(pins.kill),
		.dead_i(s_q.dead),
		.hi_o(db_hi),
		.lo_o(db_lo)
	);

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Merges a bus write into a word under the byte enables.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Comparator; an illegal mode code never asserts.
	function automatic logic cmp_eval(input tcp_cmp_t mode, input logic [TCP_CNT_W-1:0] cnt,
			input logic [TCP_CNT_W-1:0] cv);
		logic r;
		r = 1'b0;
		case (mode)
			TCP_CMP_LESS_THAN: r = cnt < cv; // R3
			TCP_CMP_LESS_OR_EQUAL: r = cnt <= cv; // R3
			TCP_CMP_SAME_VALUE: r = cnt == cv; // R3
			TCP_CMP_GREATER_OR_EQUAL: r = cnt >= cv; // R3
			TCP_CMP_GREATER_THAN: r = cnt > cv; // R3
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign cmp_true = cmp_eval(s_q.cmp_mode, s_q.count, s_q.compare);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	logic hit;
	logic wr;
	logic tick;
	logic gate_ok;
	logic rst_ev;
	logic cap_ev;
	logic [31:0] ctrl_w;
	logic [31:0] wd;
	logic [TCP_EV_N-1:0] ev;
	logic [TCP_EV_N-1:0] clr;

	// Bus decode, counter, events and registers are all computed here.
	always_comb begin
		s_d = s_q;
		ev = '0;
		clr = '0;
		tick = 1'b0;
		hit = wb_cyc_i & wb_stb_i;
		// A write lands on the edge where the master sees ack.
		wr = hit & s_q.ack & wb_we_i;
		rst_ev = pins.restart & ~s_q.prev.restart; // R11
		cap_ev = pins.capture & ~s_q.prev.capture; // R11
		gate_ok = (s_q.mode != TCP_RUN_GATED) | pins.enable; // R6
		s_d.prev = pins;
		s_d.tc_pulse = 1'b0;
		ctrl_w = '0;
		ctrl_w[TCP_CTRL_EN] = s_q.en;
		ctrl_w[TCP_CTRL_MODE_LSB +: 2] = s_q.mode;
		ctrl_w[TCP_CTRL_CLK_LSB +: 2] = s_q.clk_src;
		ctrl_w[TCP_CTRL_CMP_LSB +: 3] = s_q.cmp_mode;
		ctrl_w[TCP_CTRL_CPL] = s_q.cpl;
		ctrl_w[TCP_CTRL_DB_LSB +: DB_W] = s_q.dead;

		// Clock source selection; the divider rolls over at the prescale value.
		// A prescale of zero makes the divided source tick on every clock.
		// External sources are edge-detected after the synchroniser, so each level must
		// last at least two system clocks to be seen.
		if (s_q.div_cnt >= s_q.prescale) begin
			s_d.div_cnt = '0;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 1'b1;
		end
		case (s_q.clk_src)
			TCP_CLK_SYS: tick = 1'b1; // R12
			TCP_CLK_DIV: tick = s_q.div_cnt >= s_q.prescale; // R12
			TCP_CLK_EXT_RISE: tick = pins.ext_clk & ~s_q.prev.ext_clk; // R12
			TCP_CLK_EXT_FALL: tick = ~pins.ext_clk & s_q.prev.ext_clk; // R12
			default: tick = 1'b0;
		endcase

		// Run control and counting.
		unique case (s_q.fsm)
			TCP_ST_IDLE: begin
				// Starting always reloads, so a stale count never leaks into a new run.
				if (s_q.en) begin
					s_d.fsm = TCP_ST_COUNT;
					s_d.count = s_q.period; // R2
				end
			end
			TCP_ST_COUNT: begin
				if (!s_q.en) begin
					s_d.fsm = TCP_ST_IDLE;
				end else if (rst_ev) begin
					// A restart edge outranks a tick in the same cycle.
					s_d.count = s_q.period; // R2
				end else if (tick && gate_ok) begin
					if (s_q.count == '0) begin
						// The pulse lasts one system clock whatever the tick source.
						s_d.tc_pulse = 1'b1; // R13
						ev[TCP_EV_TC] = 1'b1;
						if (s_q.mode == TCP_RUN_ONESHOT) begin
							s_d.fsm = TCP_ST_HALT; // R5
						end else begin
							s_d.count = s_q.period; // R2
						end
					end else begin
						s_d.count = s_q.count - 1'b1; // R1
					end
				end
			end
			TCP_ST_HALT: begin
				// A halted one-shot re-arms on a restart or a new enable.
				if (!s_q.en) begin
					s_d.fsm = TCP_ST_IDLE;
				end else if (rst_ev) begin
					s_d.fsm = TCP_ST_COUNT;
					s_d.count = s_q.period; // R2
				end
			end
		endcase

		// Capture takes the count as it stands, without touching it.
		// A capture edge in a reload cycle records the count from before the reload.
		if (cap_ev) begin
			s_d.capture = s_q.count; // R10
			ev[TCP_EV_CAP] = 1'b1;
		end
		// Only a rising compare level outside idle (counting or halted) counts as a compare event.
		s_d.cmp_prev = cmp_true;
		ev[TCP_EV_CMP] = cmp_true & ~s_q.cmp_prev & (s_q.fsm != TCP_ST_IDLE);

		// Register writes.
		if (wr) begin
			unique case (wb_adr_i)
				TCP_OFS_CTRL: begin
					wd = merge(ctrl_w, wb_dat_i, wb_sel_i);
					s_d.en = wd[TCP_CTRL_EN];
					s_d.mode = tcp_run_t'(wd[TCP_CTRL_MODE_LSB +: 2]); // R6
					s_d.clk_src = tcp_clk_t'(wd[TCP_CTRL_CLK_LSB +: 2]); // R12
					s_d.cmp_mode = tcp_cmp_t'(wd[TCP_CTRL_CMP_LSB +: 3]); // R3
					s_d.cpl = wd[TCP_CTRL_CPL]; // R9
					s_d.dead = wd[TCP_CTRL_DB_LSB +: DB_W]; // R8
				end
				TCP_OFS_PERIOD: begin
					wd = merge({16'h0000, s_q.period}, wb_dat_i, wb_sel_i);
					s_d.period = wd[TCP_CNT_W-1:0];
				end
				TCP_OFS_COMPARE: begin
					wd = merge({16'h0000, s_q.compare}, wb_dat_i, wb_sel_i);
					s_d.compare = wd[TCP_CNT_W-1:0];
				end
				TCP_OFS_STATUS: begin
					wd = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
					clr = wd[TCP_EV_N-1:0];
				end
				TCP_OFS_MASK: begin
					wd = merge({29'h0000_0000, s_q.mask}, wb_dat_i, wb_sel_i);
					s_d.mask = wd[TCP_EV_N-1:0];
				end
				TCP_OFS_PRESCALE: begin
					wd = merge({16'h0000, s_q.prescale}, wb_dat_i, wb_sel_i);
					s_d.prescale = wd[TCP_CNT_W-1:0];
				end
				default: wd = '0;
			endcase
		end else begin
			wd = '0;
		end

		// Sticky events: a new event in the clearing cycle survives the clear.
		s_d.status = (s_q.status & ~clr) | ev; // R4

		// Ack one cycle after the request, then drop; reads are sampled here.
		s_d.ack = hit & ~s_q.ack;
		s_d.rdata = '0;
		// Writes return zero data, so a write ack never shows a stale register.
		if (hit && !s_q.ack && !wb_we_i) begin
			unique case (wb_adr_i)
				TCP_OFS_CTRL: s_d.rdata = ctrl_w;
				TCP_OFS_PERIOD: s_d.rdata = {16'h0000, s_q.period};
				TCP_OFS_COMPARE: s_d.rdata = {16'h0000, s_q.compare};
				TCP_OFS_COUNT: s_d.rdata = {16'h0000, s_q.count}; // R14
				TCP_OFS_CAPTURE: s_d.rdata = {16'h0000, s_q.capture}; // R10
				TCP_OFS_STATUS: begin
					s_d.rdata[TCP_EV_N-1:0] = s_q.status;
					s_d.rdata[TCP_ST_RUN] = s_q.fsm == TCP_ST_COUNT;
				end
				TCP_OFS_MASK: s_d.rdata[TCP_EV_N-1:0] = s_q.mask;
				TCP_OFS_PRESCALE: s_d.rdata = {16'h0000, s_q.prescale};
				default: s_d.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset loads constants only; the timer comes up stopped.
	// Fields not named here reset to zero with the rest of the struct.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.fsm <= TCP_ST_IDLE;
			s_q.mode <= TCP_RUN_FREE;
			s_q.clk_src <= TCP_CLK_SYS;
			s_q.cmp_mode <= TCP_CMP_LESS_THAN;
			s_q.period <= TCP_RST_PERIOD;
			s_q.compare <= TCP_RST_COMPARE;
			s_q.prescale <= TCP_RST_PRESCALE;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;
	// Kill acts inside the deadband stage, so both pins of the pair drop together.
	assign cmp_o = db_hi; // R9
	// The terminal-count pin carries the complement when that option is set.
	assign tc_o = s_q.cpl ? db_lo : s_q.tc_pulse; // R9
	// Level interrupt, high while any unmasked sticky bit is set.
	assign irq_o = |(s_q.status & s_q.mask); // R4

endmodule

//--- sim/tcp_checker.sv
`timescale 1ns/1ps
// Port watcher: bus answer timing, quiet outputs after reset, kill and irq causes.
module tcp_checker (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus side.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Routed side.
	input wire logic kill_i,
	input wire logic cmp_o,
	input wire logic tc_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	// Bus answers are fixed at one cycle, so any stall or doubled ack is a fault.
	AST_ACK_ANS: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack wider than one cycle");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_DAT_IDLE: assert property (!wb_ack_o || wb_we_i |-> wb_dat_o == 32'h0)
		else $error("read data outside a read ack");

	////////////////////////////////////////////////////////////////////////////
	// Outputs and their causes; five cycles cover the synchroniser and output register.
	AST_KILL: assert property (kill_i [*5] |-> !cmp_o)
		else $error("compare output high under kill");
	AST_RST_QUIET: assert property ($fell(rst_i) |-> (!cmp_o && !tc_o && !irq_o) [*3])
		else $error("output active just after reset");
	AST_IRQ_FALL: assert property ($fell(irq_o) |->
		$past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
		else $error("irq dropped without a register write");
	AST_TC_AFTER_RST: assert property ($fell(rst_i) |=> !tc_o ##1 !tc_o)
		else $error("terminal count before any start");

	// Main scenarios.
	cover property (wb_ack_o && wb_we_i);
	cover property ($rose(irq_o));
	cover property ($rose(tc_o));
	cover property (kill_i && $fell(cmp_o));
endmodule

bind tcp_timer tcp_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
	.wb_ack_o, .kill_i, .cmp_o, .tc_o, .irq_o);

//--- sim/tcp_route_model.sv
`timescale 1ns/1ps
// Far-side routing logic: steady levels, held pulses and a free external clock.
module tcp_route_model (
	// Clock.
	input wire logic clk_i,
	// Routed signals toward the timer.
	output logic ext_clk_o,
	output logic restart_o,
	output logic capture_o,
	output logic kill_o,
	output logic enable_o
);
	logic [1:0] div_q;

	initial begin
		div_q = 2'h0;
		ext_clk_o = 1'b0;
		restart_o = 1'b0;
		capture_o = 1'b0;
		kill_o = 1'b0;
		enable_o = 1'b0;
	end

	// External count clock toggles every four clocks so each level outlives the synchroniser.
	always @(posedge clk_i) begin
		div_q <= div_q + 2'h1;
		if (div_q == 2'h3) begin
			ext_clk_o <= !ext_clk_o;
		end
	end

	// Restart or capture pulse, held four clocks so no edge is lost in synchronising.
	task automatic pulse(input logic cap);
		@(posedge clk_i);
		if (cap) begin
			capture_o <= 1'b1;
		end else begin
			restart_o <= 1'b1;
		end
		repeat (4) @(posedge clk_i);
		capture_o <= 1'b0;
		restart_o <= 1'b0;
	endtask

	// Kill and enable levels.
	task automatic levels(input logic k, input logic e);
		@(posedge clk_i);
		kill_o <= k;
		enable_o <= e;
	endtask
endmodule

//--- sim/tcp_timer_tb.sv
`timescale 1ns/1ps
// Self-checking bench of the timer through its bus and routed pins.
module tcp_timer_tb
	import tcp_pkg::*;
;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic ext_clk_i, restart_i, capture_i, kill_i, enable_i, cmp_o, tc_o, irq_o;
	int n_fail, n_checks, g;
	// Compare rows: {mode, expected level, period}; compare value is 16'h0010.
	logic [19:0] crow [10] = '{20'h00010, 20'h1000f, 20'h30010, 20'h20011, 20'h50010,
		20'h4000f, 20'h70010, 20'h6000f, 20'h80010, 20'h90011};
	// Clock source rows: {control byte, expected tc spacing} for a period of 2.
	logic [15:0] srow [5] = '{16'h0103, 16'h0906, 16'h1118, 16'h1918, 16'h0503};
	// Reset rows: {address, value}; the last address is unmapped.
	logic [39:0] rrow [9] = '{40'h0000000000, 40'h040000ffff, 40'h0800008000, 40'h0c00000000,
		40'h1000000000, 40'h1400000000, 40'h1800000000, 40'h1c00000000, 40'h2000000000};

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	tcp_timer dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_clk_i, .restart_i, .capture_i, .kill_i,
		.enable_i, .cmp_o, .tc_o, .irq_o);
	tcp_route_model route (.clk_i, .ext_clk_o(ext_clk_i), .restart_o(restart_i),
		.capture_o(capture_i), .kill_o(kill_i), .enable_o(enable_i));

	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; the ack is sampled at the edge, so a hung slave ends the run.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1) break;
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (i == 20) begin
			n_fail++;
			report_and_stop();
		end
	endtask

	// Cycles from one terminal-count pulse to the next; a width above one shows as 1.
	task automatic tc_gap(output int gap);
		int i;
		for (i = 0; i < 300 && tc_o !== 1'b1; i++) @(posedge clk_i);
		@(posedge clk_i);
		for (gap = 1; gap < 300 && tc_o !== 1'b1; gap++) @(posedge clk_i);
	endtask

	task automatic cnt_tc(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge clk_i);
			if (tc_o === 1'b1) k++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		n_fail = 0;
		n_checks = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// Writes to read-only and unmapped places must leave nothing behind.
		wb(1'b1, TCP_OFS_COUNT, 32'h5a);
		wb(1'b1, 8'h20, 32'h5a);
		foreach (rrow[r]) begin
			wb(1'b0, rrow[r][39:32], 32'h0);
			chk("reset value", rrow[r][31:0], rd);
		end
		$display("test reset done");
		// Gated mode with enable low holds the loaded period, so the compare level is steady.
		wb(1'b1, TCP_OFS_COMPARE, 32'h10);
		foreach (crow[r]) begin
			wb(1'b1, TCP_OFS_CTRL, 32'h0);
			wb(1'b1, TCP_OFS_PERIOD, {16'h0, crow[r][15:0]});
			wb(1'b1, TCP_OFS_CTRL, {24'h0, crow[r][19:17], 5'h05});
			repeat (6) @(posedge clk_i);
			chk("compare level", {31'h0, crow[r][16]}, {31'h0, cmp_o});
			wb(1'b0, TCP_OFS_COUNT, 32'h0);
			chk("held count", {16'h0, crow[r][15:0]}, rd);
		end
		$display("test compare modes done");
		route.levels(1'b0, 1'b1);
		wb(1'b1, TCP_OFS_PRESCALE, 32'h1);
		foreach (srow[r]) begin
			wb(1'b1, TCP_OFS_CTRL, 32'h0);
			wb(1'b1, TCP_OFS_PERIOD, 32'h2);
			wb(1'b1, TCP_OFS_CTRL, {24'h0, srow[r][15:8]});
			tc_gap(g);
			chk("tc spacing", {24'h0, srow[r][7:0]}, g);
		end
		$display("test clock sources done");
		// One-shot stops once, raises and clears the interrupt, then re-arms on restart.
		route.levels(1'b0, 1'b0);
		wb(1'b1, TCP_OFS_CTRL, 32'h0);
		wb(1'b1, TCP_OFS_PERIOD, 32'h8);
		wb(1'b1, TCP_OFS_STATUS, 32'h7);
		wb(1'b1, TCP_OFS_CTRL, 32'h3);
		cnt_tc(40, g);
		chk("one-shot pulses", 32'h1, g);
		wb(1'b0, TCP_OFS_COUNT, 32'h0);
		chk("halted count", 32'h0, rd);
		wb(1'b0, TCP_OFS_STATUS, 32'h0);
		chk("tc event", 32'h1, rd & 32'h1);
		chk("irq masked", 32'h0, irq_o);
		wb(1'b1, TCP_OFS_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("irq raised", 32'h1, irq_o);
		wb(1'b1, TCP_OFS_STATUS, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0, irq_o);
		route.pulse(1'b0);
		cnt_tc(40, g);
		chk("restart pulses", 32'h1, g);
		$display("test one-shot done");
		// Capture, kill and the complementary pair with a dead gap of three clocks.
		wb(1'b1, TCP_OFS_CTRL, 32'h0);
		wb(1'b1, TCP_OFS_STATUS, 32'h7);
		wb(1'b1, TCP_OFS_PERIOD, 32'h1234);
		wb(1'b1, TCP_OFS_CTRL, 32'h65);
		route.pulse(1'b1);
		repeat (2) @(posedge clk_i);
		wb(1'b0, TCP_OFS_CAPTURE, 32'h0);
		chk("capture", 32'h1234, rd);
		wb(1'b0, TCP_OFS_STATUS, 32'h0);
		chk("capture event", 32'h4, rd & 32'h4);
		chk("compare event", 32'h2, rd & 32'h2);
		wb(1'b1, TCP_OFS_MASK, 32'h4);
		repeat (2) @(posedge clk_i);
		chk("irq on capture", 32'h1, irq_o);
		chk("compare high", 32'h1, cmp_o);
		route.levels(1'b1, 1'b0);
		repeat (5) @(posedge clk_i);
		chk("killed", 32'h0, cmp_o);
		route.levels(1'b0, 1'b0);
		repeat (5) @(posedge clk_i);
		chk("unkilled", 32'h1, cmp_o);
		wb(1'b1, TCP_OFS_CTRL, 32'h30165);
		repeat (6) @(posedge clk_i);
		chk("complement low", 32'h0, tc_o);
		wb(1'b1, TCP_OFS_COMPARE, 32'hffff);
		for (g = 0; g < 50 && cmp_o !== 1'b0; g++) @(posedge clk_i);
		for (g = 0; g < 50 && tc_o !== 1'b1; g++) @(posedge clk_i);
		chk("dead gap", 32'h1, (g >= 3 && g <= 4));
		route.levels(1'b1, 1'b0);
		repeat (5) @(posedge clk_i);
		chk("complement killed", 32'h0, tc_o);
		$display("test capture and outputs done");
		// Reset in mid-run: registers and outputs return to their reset state.
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("reset cmp", 32'h0, cmp_o);
		chk("reset tc", 32'h0, tc_o);
		wb(1'b0, TCP_OFS_CTRL, 32'h0);
		chk("reset ctrl", 32'h0, rd);
		wb(1'b0, TCP_OFS_PERIOD, 32'h0);
		chk("reset period", {16'h0, TCP_RST_PERIOD}, rd);
		wb(1'b0, TCP_OFS_STATUS, 32'h0);
		chk("reset status", 32'h0, rd);
		chk("reset irq", 32'h0, irq_o);
		$display("test mid-run reset done");
		report_and_stop();
	end
endmodule
